// File: sfrm_defs.svh
`ifndef SFRM_DEFS_SVH
`define SFRM_DEFS_SVH

// Upper address byte that selects the register window.
`define SFRM_WIN_BASE 8'hff

`define SFRM_ADDR_PORT2_DATA 16'hff02
`define SFRM_ADDR_PORT3_DATA 16'hff03
`define SFRM_ADDR_PORT4_DATA 16'hff04
`define SFRM_ADDR_CMP_LOW 16'hff0e
`define SFRM_ADDR_CMP_HIGH 16'hff0f
`define SFRM_ADDR_COUNT 16'hff12
`define SFRM_ADDR_COUNT_HI 16'hff13
`define SFRM_ADDR_CAPCMP_A 16'hff14
`define SFRM_ADDR_CAPCMP_A_HI 16'hff15
`define SFRM_ADDR_CAPCMP_B 16'hff16
`define SFRM_ADDR_CAPCMP_B_HI 16'hff17
`define SFRM_ADDR_PORT2_DIR 16'hff22
`define SFRM_ADDR_PORT3_DIR 16'hff23
`define SFRM_ADDR_PORT4_DIR 16'hff24
`define SFRM_ADDR_PORT2_PULL 16'hff32
`define SFRM_ADDR_PORT3_PULL 16'hff33
`define SFRM_ADDR_PORT4_PULL 16'hff34
`define SFRM_ADDR_WDT_MODE 16'hff48
`define SFRM_ADDR_WDT_ENABLE 16'hff49

`define SFRM_RST_BYTE 8'h00
`define SFRM_RST_DIR 8'hff
`define SFRM_RST_WDT_MODE 8'h67
`define SFRM_RST_WDT_ENABLE 8'h9a
`define SFRM_RST_WORD 16'h0000

// Writable bits of each byte register; the rest hold the fixed value.
`define SFRM_WMASK_ALL 8'hff
`define SFRM_WMASK_PORT2 8'h0f
`define SFRM_WMASK_PORT3 8'h04
`define SFRM_WMASK_WDT_MODE 8'h1f
`define SFRM_FIXED_NONE 8'h00
`define SFRM_FIXED_DIR2 8'hf0
`define SFRM_FIXED_DIR3 8'hfb
`define SFRM_FIXED_WDT_MODE 8'h60

// Bit of the port 3 data register that shows the input-only pin.
`define SFRM_PIN_BIT 3'h4

// Register pair numbers of the general register file.
`define SFRM_ACCUMULATOR_PAIR 2'h0
`define SFRM_SECOND_REGISTER_PAIR 2'h1
`define SFRM_THIRD_REGISTER_PAIR 2'h2
`define SFRM_POINTER_REGISTER_PAIR 2'h3
`define SFRM_GPR_RST 8'h00

`endif

// File: sfrm_pkg.sv
`default_nettype none
package sfrm_pkg;
	// Access unit; code 2'b10 is illegal and is refused by every register.
	typedef enum logic [1:0] {
		SFRM_WBIT = 2'h0,
		SFRM_WBYTE = 2'h1,
		SFRM_WWORD = 2'h3
	} sfrm_width_t;
endpackage
`default_nettype wire

// File: sfrm_gpr.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfrm_defs.svh"
module sfrm_gpr import sfrm_pkg::*; (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic gpr_wr_i,
	input wire logic gpr_word_i,
	input wire logic [2:0] gpr_idx_i,
	input wire logic [15:0] gpr_wdata_i,
	output logic [15:0] gpr_rdata_o
);
	logic [7:0] gpr_reg [0:7];
	logic [7:0] gpr_next [0:7];
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [2:0] lo_idx;
	logic [2:0] hi_idx;

	// Pair p is byte 2p as its low half and byte 2p+1 as its high half.
	assign lo_idx = {gpr_idx_i[2:1], 1'b0};
	assign hi_idx = {gpr_idx_i[2:1], 1'b1};

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			gpr_next[i] = gpr_reg[i];
		end
		if (gpr_wr_i && gpr_word_i) begin
			gpr_next[lo_idx] = gpr_wdata_i[7:0];
			gpr_next[hi_idx] = gpr_wdata_i[15:8];
		end else if (gpr_wr_i) begin
			gpr_next[gpr_idx_i] = gpr_wdata_i[7:0];
		end
		if (gpr_word_i) begin
			rdata_next = {gpr_reg[hi_idx], gpr_reg[lo_idx]};
		end else begin
			rdata_next = {8'h00, gpr_reg[gpr_idx_i]};
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 8; i++) begin
				gpr_reg[i] <= `SFRM_GPR_RST;
			end
			rdata_reg <= 16'h0000;
		end else begin
			for (int i = 0; i < 8; i++) begin
				gpr_reg[i] <= gpr_next[i];
			end
			rdata_reg <= rdata_next;
		end
	end

	assign gpr_rdata_o = rdata_reg;

	pair_write_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		gpr_wr_i && gpr_word_i |=>
		{gpr_reg[$past(hi_idx)], gpr_reg[$past(lo_idx)]} == $past(gpr_wdata_i))
		else $error("pair write did not land in both bytes");

	byte_write_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		gpr_wr_i && !gpr_word_i |=>
		gpr_reg[$past(gpr_idx_i)] == $past(gpr_wdata_i[7:0]))
		else $error("byte write lost");
endmodule
`default_nettype wire

// File: sfrm_bank.sv
// Contract
// - Decode registers in window FF00H to FFFFH.
// - Each register accepts only its access widths.
// - Bit access by address plus bit position.
// - Read-only ignores writes; write-only reads meaningless.
// - Reset loads each listed initial value.
// - Eight byte registers, combinable into four pairs.
// - Input-only pin bit reflects pin, unwritable.
`timescale 1ns/1ps
`default_nettype none
`include "sfrm_defs.svh"
module sfrm_bank import sfrm_pkg::*; (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [15:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire sfrm_width_t width_i,
	input wire logic [2:0] bitpos_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic err_o,
	output logic hit_o,
	input wire logic input_only_port_pin_i,
	input wire logic [15:0] timer16_count_i,
	output logic [7:0] port2_data_o,
	output logic [7:0] port3_data_o,
	output logic [7:0] port4_data_o,
	output logic [7:0] timer8_compare_low_o,
	output logic [7:0] timer8_compare_high_o,
	output logic [15:0] timer16_capture_compare_a_o,
	output logic [15:0] timer16_capture_compare_b_o,
	output logic [7:0] port2_direction_o,
	output logic [7:0] port3_direction_o,
	output logic [7:0] port4_direction_o,
	output logic [7:0] port2_pullup_o,
	output logic [7:0] port3_pullup_o,
	output logic [7:0] port4_pullup_o,
	output logic [7:0] watchdog_mode_o,
	output logic [7:0] watchdog_enable_o,
	input wire logic gpr_wr_i,
	input wire logic gpr_word_i,
	input wire logic [2:0] gpr_idx_i,
	input wire logic [15:0] gpr_wdata_i,
	output logic [15:0] gpr_rdata_o
);
	logic [7:0] port2_data_reg, port2_data_next;
	logic [7:0] port3_data_reg, port3_data_next;
	logic [7:0] port4_data_reg, port4_data_next;
	logic [7:0] cmp_low_reg, cmp_low_next;
	logic [7:0] cmp_high_reg, cmp_high_next;
	logic [15:0] capcmp_a_reg, capcmp_a_next;
	logic [15:0] capcmp_b_reg, capcmp_b_next;
	logic [7:0] port2_dir_reg, port2_dir_next;
	logic [7:0] port3_dir_reg, port3_dir_next;
	logic [7:0] port4_dir_reg, port4_dir_next;
	logic [7:0] port2_pull_reg, port2_pull_next;
	logic [7:0] port3_pull_reg, port3_pull_next;
	logic [7:0] port4_pull_reg, port4_pull_next;
	logic [7:0] wdt_mode_reg, wdt_mode_next;
	logic [7:0] wdt_enable_reg, wdt_enable_next, byte_val;
	logic [15:0] rdata_reg, rdata_next, read_val;
	logic err_reg, err_next, first_reg;
	logic in_win, width_ok, wr_go;

	// Store a byte or a single bit; fixed bits always take their value.
	function automatic logic [7:0] sfrm_merge(input logic [7:0] cur,
		input logic [7:0] wd, input logic [7:0] wmask,
		input logic [7:0] fixed, input sfrm_width_t w,
		input logic [2:0] pos);
		logic [7:0] v;
		v = wd;
		if (w == SFRM_WBIT) begin
			v = cur;
			v[pos] = wd[0];
		end
		return (v & wmask) | (fixed & ~wmask);
	endfunction
	// Access units that each address accepts.
	function automatic logic sfrm_width_ok(input logic [15:0] a,
		input sfrm_width_t w);
		logic ok;
		ok = 1'b1;
		case (a)
			`SFRM_ADDR_PORT2_DATA, `SFRM_ADDR_PORT3_DATA,
			`SFRM_ADDR_PORT4_DATA, `SFRM_ADDR_PORT2_DIR,
			`SFRM_ADDR_PORT3_DIR, `SFRM_ADDR_PORT4_DIR,
			`SFRM_ADDR_PORT2_PULL, `SFRM_ADDR_PORT3_PULL,
			`SFRM_ADDR_PORT4_PULL: begin
				ok = (w == SFRM_WBIT) || (w == SFRM_WBYTE);
			end
			`SFRM_ADDR_CMP_LOW, `SFRM_ADDR_CMP_HIGH,
			`SFRM_ADDR_WDT_MODE, `SFRM_ADDR_WDT_ENABLE: begin
				ok = (w == SFRM_WBYTE);
			end
			`SFRM_ADDR_COUNT, `SFRM_ADDR_CAPCMP_A,
			`SFRM_ADDR_CAPCMP_B: begin
				ok = (w == SFRM_WWORD);
			end
			// The odd half of a word register is never addressed alone.
			`SFRM_ADDR_COUNT_HI, `SFRM_ADDR_CAPCMP_A_HI,
			`SFRM_ADDR_CAPCMP_B_HI: begin
				ok = 1'b0;
			end
			default: begin
				ok = (w != 2'h2);
			end
		endcase
		return ok;
	endfunction
	assign in_win = (addr_i[15:8] == `SFRM_WIN_BASE);
	assign width_ok = sfrm_width_ok(addr_i, width_i);
	assign wr_go = wr_i && in_win && width_ok;
	assign hit_o = in_win;
	always_comb begin
		port2_data_next = port2_data_reg;
		port3_data_next = port3_data_reg;
		port4_data_next = port4_data_reg;
		cmp_low_next = cmp_low_reg;
		cmp_high_next = cmp_high_reg;
		capcmp_a_next = capcmp_a_reg;
		capcmp_b_next = capcmp_b_reg;
		port2_dir_next = port2_dir_reg;
		port3_dir_next = port3_dir_reg;
		port4_dir_next = port4_dir_reg;
		port2_pull_next = port2_pull_reg;
		port3_pull_next = port3_pull_reg;
		port4_pull_next = port4_pull_reg;
		wdt_mode_next = wdt_mode_reg;
		wdt_enable_next = wdt_enable_reg;
		if (wr_go) begin
			case (addr_i)
				`SFRM_ADDR_PORT2_DATA: port2_data_next = sfrm_merge(
					port2_data_reg, wdata_i[7:0], `SFRM_WMASK_PORT2,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_PORT3_DATA: port3_data_next = sfrm_merge(
					port3_data_reg, wdata_i[7:0], `SFRM_WMASK_PORT3,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_PORT4_DATA: port4_data_next = sfrm_merge(
					port4_data_reg, wdata_i[7:0], `SFRM_WMASK_ALL,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_CMP_LOW: cmp_low_next = wdata_i[7:0];
				`SFRM_ADDR_CMP_HIGH: cmp_high_next = wdata_i[7:0];
				`SFRM_ADDR_CAPCMP_A: capcmp_a_next = wdata_i;
				`SFRM_ADDR_CAPCMP_B: capcmp_b_next = wdata_i;
				`SFRM_ADDR_PORT2_DIR: port2_dir_next = sfrm_merge(
					port2_dir_reg, wdata_i[7:0], `SFRM_WMASK_PORT2,
					`SFRM_FIXED_DIR2, width_i, bitpos_i);
				`SFRM_ADDR_PORT3_DIR: port3_dir_next = sfrm_merge(
					port3_dir_reg, wdata_i[7:0], `SFRM_WMASK_PORT3,
					`SFRM_FIXED_DIR3, width_i, bitpos_i);
				`SFRM_ADDR_PORT4_DIR: port4_dir_next = sfrm_merge(
					port4_dir_reg, wdata_i[7:0], `SFRM_WMASK_ALL,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_PORT2_PULL: port2_pull_next = sfrm_merge(
					port2_pull_reg, wdata_i[7:0], `SFRM_WMASK_PORT2,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_PORT3_PULL: port3_pull_next = sfrm_merge(
					port3_pull_reg, wdata_i[7:0], `SFRM_WMASK_PORT3,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_PORT4_PULL: port4_pull_next = sfrm_merge(
					port4_pull_reg, wdata_i[7:0], `SFRM_WMASK_ALL,
					`SFRM_FIXED_NONE, width_i, bitpos_i);
				`SFRM_ADDR_WDT_MODE: wdt_mode_next = sfrm_merge(
					wdt_mode_reg, wdata_i[7:0], `SFRM_WMASK_WDT_MODE,
					`SFRM_FIXED_WDT_MODE, width_i, bitpos_i);
				`SFRM_ADDR_WDT_ENABLE: wdt_enable_next = wdata_i[7:0];
				default: begin
				end
			endcase
		end
	end
	always_comb begin
		byte_val = 8'h00;
		read_val = 16'h0000;
		case (addr_i)
			`SFRM_ADDR_PORT2_DATA: byte_val = port2_data_reg;
			`SFRM_ADDR_PORT3_DATA: byte_val = port3_data_reg |
				({7'h00, input_only_port_pin_i} << `SFRM_PIN_BIT);
			`SFRM_ADDR_PORT4_DATA: byte_val = port4_data_reg;
			`SFRM_ADDR_CMP_LOW: byte_val = cmp_low_reg;
			`SFRM_ADDR_CMP_HIGH: byte_val = cmp_high_reg;
			`SFRM_ADDR_PORT2_DIR: byte_val = port2_dir_reg;
			`SFRM_ADDR_PORT3_DIR: byte_val = port3_dir_reg;
			`SFRM_ADDR_PORT4_DIR: byte_val = port4_dir_reg;
			`SFRM_ADDR_PORT2_PULL: byte_val = port2_pull_reg;
			`SFRM_ADDR_PORT3_PULL: byte_val = port3_pull_reg;
			`SFRM_ADDR_PORT4_PULL: byte_val = port4_pull_reg;
			`SFRM_ADDR_WDT_MODE: byte_val = wdt_mode_reg;
			`SFRM_ADDR_WDT_ENABLE: byte_val = wdt_enable_reg;
			`SFRM_ADDR_COUNT: read_val = timer16_count_i;
			`SFRM_ADDR_CAPCMP_A: read_val = capcmp_a_reg;
			`SFRM_ADDR_CAPCMP_B: read_val = capcmp_b_reg;
		endcase
		if (width_i == SFRM_WBIT) begin
			read_val = {15'h0000, byte_val[bitpos_i]};
		end else if (width_i == SFRM_WBYTE) begin
			read_val = {8'h00, byte_val};
		end
	end
	// Read data holds until the next read, so a slow sampler is safe.
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_i && in_win) begin
			rdata_next = width_ok ? read_val : 16'h0000;
		end
		err_next = (rd_i || wr_i) && in_win && !width_ok;
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port2_data_reg <= `SFRM_RST_BYTE;
			port3_data_reg <= `SFRM_RST_BYTE;
			port4_data_reg <= `SFRM_RST_BYTE;
			cmp_low_reg <= `SFRM_RST_BYTE;
			cmp_high_reg <= `SFRM_RST_BYTE;
			capcmp_a_reg <= `SFRM_RST_WORD;
			capcmp_b_reg <= `SFRM_RST_WORD;
			port2_dir_reg <= `SFRM_RST_DIR;
			port3_dir_reg <= `SFRM_RST_DIR;
			port4_dir_reg <= `SFRM_RST_DIR;
			port2_pull_reg <= `SFRM_RST_BYTE;
			port3_pull_reg <= `SFRM_RST_BYTE;
			port4_pull_reg <= `SFRM_RST_BYTE;
			wdt_mode_reg <= `SFRM_RST_WDT_MODE;
			wdt_enable_reg <= `SFRM_RST_WDT_ENABLE;
			rdata_reg <= 16'h0000;
			err_reg <= 1'b0;
			first_reg <= 1'b1;
		end else begin
			port2_data_reg <= port2_data_next;
			port3_data_reg <= port3_data_next;
			port4_data_reg <= port4_data_next;
			cmp_low_reg <= cmp_low_next;
			cmp_high_reg <= cmp_high_next;
			capcmp_a_reg <= capcmp_a_next;
			capcmp_b_reg <= capcmp_b_next;
			port2_dir_reg <= port2_dir_next;
			port3_dir_reg <= port3_dir_next;
			port4_dir_reg <= port4_dir_next;
			port2_pull_reg <= port2_pull_next;
			port3_pull_reg <= port3_pull_next;
			port4_pull_reg <= port4_pull_next;
			wdt_mode_reg <= wdt_mode_next;
			wdt_enable_reg <= wdt_enable_next;
			rdata_reg <= rdata_next;
			err_reg <= err_next;
			first_reg <= 1'b0;
		end
	end
	assign rdata_o = rdata_reg;
	assign err_o = err_reg;
	assign port2_data_o = port2_data_reg;
	assign port3_data_o = port3_data_reg;
	assign port4_data_o = port4_data_reg;
	assign timer8_compare_low_o = cmp_low_reg;
	assign timer8_compare_high_o = cmp_high_reg;
	assign timer16_capture_compare_a_o = capcmp_a_reg;
	assign timer16_capture_compare_b_o = capcmp_b_reg;
	assign port2_direction_o = port2_dir_reg;
	assign port3_direction_o = port3_dir_reg;
	assign port4_direction_o = port4_dir_reg;
	assign port2_pullup_o = port2_pull_reg;
	assign port3_pullup_o = port3_pull_reg;
	assign port4_pullup_o = port4_pull_reg;
	assign watchdog_mode_o = wdt_mode_reg;
	assign watchdog_enable_o = wdt_enable_reg;
	sfrm_gpr u_sfrm_gpr (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.gpr_wr_i(gpr_wr_i),
		.gpr_word_i(gpr_word_i),
		.gpr_idx_i(gpr_idx_i),
		.gpr_wdata_i(gpr_wdata_i),
		.gpr_rdata_o(gpr_rdata_o)
	);
	outside_window_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		wr_i && (addr_i[15:8] != 8'hff) |=>
		$stable(port4_data_reg) && $stable(wdt_enable_reg) && !err_o)
		else $error("write outside the window changed state");
	width_refuse_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		wr_i && addr_i == 16'hff14 && width_i == SFRM_WBYTE |=>
		err_o && $stable(capcmp_a_reg))
		else $error("byte write to word register not refused");
	bit_store_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		wr_i && addr_i == 16'hff04 && width_i == SFRM_WBIT |=>
		port4_data_o[$past(bitpos_i)] == $past(wdata_i[0]) &&
		(port4_data_o & ~(8'h01 << $past(bitpos_i))) ==
		($past(port4_data_o) & ~(8'h01 << $past(bitpos_i))))
		else $error("bit write disturbed other bits");
	word_even_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		wr_i && addr_i == 16'hff16 && width_i == SFRM_WWORD |=>
		timer16_capture_compare_b_o == $past(wdata_i))
		else $error("word write lost");
	count_read_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		rd_i && addr_i == 16'hff12 && width_i == SFRM_WWORD |=>
		rdata_o == $past(timer16_count_i) && !err_o)
		else $error("count read mismatch");
	reset_values_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		first_reg |-> watchdog_mode_o == 8'h67 &&
		watchdog_enable_o == 8'h9a && port3_direction_o == 8'hff &&
		port2_data_o == 8'h00 && timer16_capture_compare_a_o == 16'h0000)
		else $error("reset value wrong");
	pin_reflect_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		rd_i && addr_i == 16'hff03 && width_i == SFRM_WBYTE |=>
		rdata_o[4] == $past(input_only_port_pin_i) && !port3_data_o[4])
		else $error("input-only pin bit wrong");
	unmapped_zero_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		rd_i && addr_i == 16'hff05 && width_i == SFRM_WBYTE |=>
		rdata_o == 16'h0000 && !err_o)
		else $error("unmapped location not zero");
	fixed_bits_a: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		wr_i |=> watchdog_mode_o[7:5] == 3'h3 &&
		port2_direction_o[7:4] == 4'hf && port2_data_o[7:4] == 4'h0)
		else $error("fixed bit changed");
endmodule
`default_nettype wire

// File: sfrm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfrm_cpu_model import sfrm_pkg::*; (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	input wire logic err_i,
	output logic [15:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output sfrm_width_t width_o,
	output logic [2:0] bitpos_o,
	output logic [15:0] wdata_o
);
	initial begin
		addr_o = 16'h0000;
		rd_o = 1'b0;
		wr_o = 1'b0;
		width_o = SFRM_WBYTE;
		bitpos_o = 3'h0;
		wdata_o = 16'h0000;
	end

	// The request stands for one taking edge; then the bus is released.
	task automatic access(input logic rd, input logic wr,
		input logic [15:0] addr, input logic [1:0] width,
		input logic [2:0] pos, input logic [15:0] data,
		output logic [15:0] q, output logic e);
		logic [15:0] a;
		a = addr;
		if (width == 2'h3) begin
			a[0] = 1'b0;
		end
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= rd;
		wr_o <= wr;
		width_o <= sfrm_width_t'(width);
		bitpos_o <= pos;
		wdata_o <= data;
		@(posedge clk_i);
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		// Released address and data lines show the inverse so a stale address or data value is never seen.
		addr_o <= ~a;
		wdata_o <= ~data;
		#1;
		q = rdata_i;
		e = err_i;
	endtask
endmodule
`default_nettype wire

// File: tb_special_function_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_special_function_register_map import sfrm_pkg::*;;
	typedef struct packed {
		logic [15:0] a;
		logic [1:0] w;
		logic [15:0] d;
		logic [15:0] r;
		logic e;
	} sfrm_row_t;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [15:0] addr, wdata, rdata_o, count, gwd, gq, cca, ccb, q;
	logic rd, wr, err_o, hit_o, pin, gwr, gword, e;
	logic hit_seen = 1'b0;
	sfrm_width_t width;
	logic [2:0] bpos, gidx;
	logic [7:0] p2, p3, p4, cl, ch, d2, d3, d4, u2, u3, u4, wm, we;
	int bad_count = 0;
	int tests_run = 0;
	sfrm_row_t rows [22];

	always #5 clk_i = ~clk_i;

	// Window hit is latched while a request stands, not after release.
	always @(posedge clk_i) begin
		if (rd || wr) begin
			hit_seen <= hit_o;
		end
	end

	sfrm_cpu_model u_sfrm_cpu_model (.clk_i(clk_i), .rdata_i(rdata_o),
		.err_i(err_o), .addr_o(addr), .rd_o(rd), .wr_o(wr),
		.width_o(width), .bitpos_o(bpos), .wdata_o(wdata));

	sfrm_bank u_sfrm_bank (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
		.rd_i(rd), .wr_i(wr), .width_i(width), .bitpos_i(bpos),
		.wdata_i(wdata), .rdata_o(rdata_o), .err_o(err_o), .hit_o(hit_o),
		.input_only_port_pin_i(pin), .timer16_count_i(count),
		.port2_data_o(p2), .port3_data_o(p3), .port4_data_o(p4),
		.timer8_compare_low_o(cl), .timer8_compare_high_o(ch),
		.timer16_capture_compare_a_o(cca),
		.timer16_capture_compare_b_o(ccb),
		.port2_direction_o(d2), .port3_direction_o(d3),
		.port4_direction_o(d4), .port2_pullup_o(u2), .port3_pullup_o(u3),
		.port4_pullup_o(u4), .watchdog_mode_o(wm), .watchdog_enable_o(we),
		.gpr_wr_i(gwr), .gpr_word_i(gword), .gpr_idx_i(gidx),
		.gpr_wdata_i(gwd), .gpr_rdata_o(gq));

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic chk_reset();
		chk({p2, p3}, 16'h0000);
		chk({p4, cl}, 16'h0000);
		chk({ch, wm}, 16'h0067);
		chk({we, d2}, 16'h9aff);
		chk({d3, d4}, 16'hffff);
		chk({u2, u3}, 16'h0000);
		chk({7'h00, err_o, u4}, 16'h0000);
		chk(cca | ccb, 16'h0000);
		chk(rdata_o | gq, 16'h0000);
	endtask

	task automatic gacc(input logic w, input logic word, input logic [2:0] i,
		input logic [15:0] d);
		@(posedge clk_i);
		gwr <= w;
		gword <= word;
		gidx <= i;
		gwd <= d;
		@(posedge clk_i);
		gwr <= 1'b0;
		#1;
	endtask

	initial begin
		pin = 1'b0;
		count = 16'h0000;
		gwr = 1'b0;
		gword = 1'b0;
		gidx = 3'h0;
		gwd = 16'h0000;
		rows = '{
			'{16'hff02, 2'h1, 16'h00ff, 16'h000f, 1'b0},
			'{16'hff03, 2'h1, 16'h00ff, 16'h0004, 1'b0},
			'{16'hff04, 2'h1, 16'h005a, 16'h005a, 1'b0},
			'{16'hff0e, 2'h1, 16'h00a5, 16'h00a5, 1'b0},
			'{16'hff0f, 2'h1, 16'h003c, 16'h003c, 1'b0},
			'{16'hff14, 2'h3, 16'h1234, 16'h1234, 1'b0},
			'{16'hff16, 2'h3, 16'habcd, 16'habcd, 1'b0},
			'{16'hff22, 2'h1, 16'h0000, 16'h00f0, 1'b0},
			'{16'hff23, 2'h1, 16'h0000, 16'h00fb, 1'b0},
			'{16'hff24, 2'h1, 16'h0000, 16'h0000, 1'b0},
			'{16'hff32, 2'h1, 16'h00ff, 16'h000f, 1'b0},
			'{16'hff33, 2'h1, 16'h00ff, 16'h0004, 1'b0},
			'{16'hff34, 2'h1, 16'h00ff, 16'h00ff, 1'b0},
			'{16'hff48, 2'h1, 16'h0000, 16'h0060, 1'b0},
			'{16'hff48, 2'h1, 16'h00ff, 16'h007f, 1'b0},
			'{16'hff49, 2'h1, 16'h0055, 16'h0055, 1'b0},
			'{16'hff05, 2'h1, 16'h00ff, 16'h0000, 1'b0},
			'{16'hffff, 2'h1, 16'h00ff, 16'h0000, 1'b0},
			'{16'hff14, 2'h1, 16'h0077, 16'h0000, 1'b1},
			'{16'hff0e, 2'h0, 16'h0001, 16'h0000, 1'b1},
			'{16'hff15, 2'h1, 16'h0011, 16'h0000, 1'b1},
			'{16'hff02, 2'h2, 16'h0001, 16'h0000, 1'b1}};
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1;
		chk_reset();
		foreach (rows[k]) begin
			u_sfrm_cpu_model.access(1'b0, 1'b1, rows[k].a, rows[k].w, 3'h0,
				rows[k].d, q, e);
			chk({15'h0000, e}, {15'h0000, rows[k].e});
			u_sfrm_cpu_model.access(1'b1, 1'b0, rows[k].a, rows[k].w, 3'h0,
				16'h0000, q, e);
			chk(q, rows[k].r);
			chk({15'h0000, e}, {15'h0000, rows[k].e});
		end
		chk(cca, 16'h1234);
		chk({cl, p2}, 16'ha50f);
		u_sfrm_cpu_model.access(1'b0, 1'b1, 16'hff04, 2'h0, 3'h3, 16'h0000, q, e);
		chk({8'h00, p4}, 16'h0052);
		u_sfrm_cpu_model.access(1'b1, 1'b0, 16'hff04, 2'h0, 3'h1, 16'h0000, q, e);
		chk(q, 16'h0001);
		@(posedge clk_i);
		pin <= 1'b1;
		u_sfrm_cpu_model.access(1'b1, 1'b0, 16'hff03, 2'h1, 3'h0, 16'h0000, q, e);
		chk(q, 16'h0014);
		u_sfrm_cpu_model.access(1'b1, 1'b0, 16'hff03, 2'h0, 3'h4, 16'h0000, q, e);
		chk(q, 16'h0001);
		u_sfrm_cpu_model.access(1'b0, 1'b1, 16'hff03, 2'h0, 3'h4, 16'h0001, q, e);
		chk({8'h00, p3}, 16'h0004);
		@(posedge clk_i);
		count <= 16'hbeef;
		u_sfrm_cpu_model.access(1'b0, 1'b1, 16'hff12, 2'h3, 3'h0, 16'h1111, q, e);
		chk({15'h0000, e}, 16'h0000);
		u_sfrm_cpu_model.access(1'b1, 1'b0, 16'hff12, 2'h3, 3'h0, 16'h0000, q, e);
		chk(q, 16'hbeef);
		chk({15'h0000, hit_seen}, 16'h0001);
		u_sfrm_cpu_model.access(1'b1, 1'b1, 16'h1234, 2'h1, 3'h0, 16'h00aa, q, e);
		chk({q[15:1], e}, 16'hbeee);
		chk({15'h0000, hit_seen}, 16'h0000);
		gacc(1'b1, 1'b1, 3'h2, 16'h1234);
		gacc(1'b0, 1'b0, 3'h2, 16'h0000);
		chk({8'h00, gq[7:0]}, 16'h0034);
		gacc(1'b0, 1'b0, 3'h3, 16'h0000);
		chk({8'h00, gq[7:0]}, 16'h0012);
		gacc(1'b1, 1'b0, 3'h7, 16'h00ab);
		gacc(1'b0, 1'b1, 3'h6, 16'h0000);
		chk(gq, 16'hab00);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		#1;
		chk_reset();
		@(posedge clk_i);
		rstn_i <= 1'b1;
		u_sfrm_cpu_model.access(1'b1, 1'b0, 16'hff48, 2'h1, 3'h0, 16'h0000, q, e);
		chk(q, 16'h0067);
		test_done();
	end

	// A hang is cut short and counted as a mismatch.
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule
`default_nettype wire
